/* File: tbcc_pkg.sv */
// Notes on behaviour
// - counter reads and writes as two bytes, high 15:8, low 7:0, zero at reset.
// - capture/compare low byte at its base index, high byte at base plus one.
// - in capture mode a trigger loads capture/compare with the counter value.
// - periodic and single-shot modes use capture/compare as the counter top.
// - in 8-bit pwm mode the two capture/compare bytes act as separate registers.
// - capture/compare is a 16-bit read/write register as two bytes at indices 0x0C and 0x0D, reset zero.
`default_nettype none
package tbcc_pkg;
    localparam int CNT_W = 16;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_W = 6;
    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CTRL = 6'h00;
    localparam logic [IDX_W-1:0] IDX_STATUS = 6'h01;
    localparam logic [IDX_W-1:0] IDX_CNT_LO = 6'h0A;
    localparam logic [IDX_W-1:0] IDX_CNT_HI = 6'h0B;
    localparam logic [IDX_W-1:0] IDX_CAPCMP_LO = 6'h0C;
    localparam logic [IDX_W-1:0] IDX_CAPCMP_HI = IDX_CAPCMP_LO + 6'h01;
    // control fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int MODE_W = 2;
    // status fields
    localparam int STAT_CAPT_BIT = 0;
    localparam int STAT_MATCH_BIT = 1;
    localparam int STAT_RUN_BIT = 2;
    localparam int STAT_WAVE_BIT = 3;
    // mode encodings
    localparam logic [MODE_W-1:0] MODE_PERIODIC = 2'h0;
    localparam logic [MODE_W-1:0] MODE_SINGLE = 2'h1;
    localparam logic [MODE_W-1:0] MODE_CAPTURE = 2'h2;
    localparam logic [MODE_W-1:0] MODE_PWM8 = 2'h3;
    // reset values
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CAPCMP_RST = 16'h0000;
    localparam logic [BYTE_W-1:0] CTRL_RST = 8'h00;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;
endpackage
`default_nettype wire

/* File: tbcc_counter.sv */
`default_nettype none
module tbcc_counter
    import tbcc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // control
    input wire logic run_in,
    input wire logic [MODE_W-1:0] mode_in,
    input wire logic [CNT_W-1:0] top_in,
    // software byte writes
    input wire logic wr_lo_in,
    input wire logic wr_hi_in,
    input wire logic [BYTE_W-1:0] wr_data_in,
    // state
    output logic [CNT_W-1:0] cnt_out,
    output logic match_out,
    output logic wave_out
);
    logic [CNT_W-1:0] cnt_ff;
    logic match_ff;
    logic wave_ff;
    logic full_hit;
    logic low_hit;

    assign full_hit = (cnt_ff == top_in);
    assign low_hit = (cnt_ff[BYTE_W-1:0] == top_in[BYTE_W-1:0]);
    assign cnt_out = cnt_ff;
    assign match_out = match_ff;
    assign wave_out = wave_ff;

    // software writes win over counting so a reload is never lost
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cnt_ff <= CNT_RST;
        end else if (wr_lo_in) begin
            cnt_ff[BYTE_W-1:0] <= wr_data_in;
        end else if (wr_hi_in) begin
            cnt_ff[CNT_W-1:BYTE_W] <= wr_data_in;
        end else if (run_in) begin
            case (mode_in)
                MODE_PERIODIC: cnt_ff <= full_hit ? CNT_RST : cnt_ff + 16'h0001;
                MODE_SINGLE: cnt_ff <= full_hit ? cnt_ff : cnt_ff + 16'h0001;
                MODE_CAPTURE: cnt_ff <= cnt_ff + 16'h0001;
                MODE_PWM8: cnt_ff[BYTE_W-1:0] <= low_hit ? 8'h00 : cnt_ff[BYTE_W-1:0] + 8'h01;
                default: cnt_ff <= cnt_ff;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            match_ff <= 1'b0;
        end else begin
            match_ff <= run_in && !wr_lo_in && !wr_hi_in && (mode_in == MODE_PWM8 ? low_hit
                        : (mode_in != MODE_CAPTURE && full_hit));
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            wave_ff <= 1'b0;
        end else begin
            wave_ff <= run_in && (mode_in == MODE_PWM8)
                       && (cnt_ff[BYTE_W-1:0] < top_in[CNT_W-1:BYTE_W]);
        end
    end

    chk_cnt_lo_write: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        wr_lo_in |=> cnt_ff[BYTE_W-1:0] == $past(wr_data_in))
        else $error("counter low byte write lost");
    chk_periodic_wrap: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        run_in && mode_in == MODE_PERIODIC && full_hit && !wr_lo_in && !wr_hi_in
        |=> cnt_ff == CNT_RST && match_ff)
        else $error("periodic counter did not wrap at top");
    chk_single_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        run_in && mode_in == MODE_SINGLE && full_hit && !wr_lo_in && !wr_hi_in
        |=> $stable(cnt_ff))
        else $error("single-shot counter moved past top");
    chk_pwm_period: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        run_in && mode_in == MODE_PWM8 && low_hit && !wr_lo_in && !wr_hi_in
        |=> cnt_ff[BYTE_W-1:0] == 8'h00)
        else $error("pwm period wrap wrong");
    chk_pwm_duty: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        run_in && mode_in == MODE_PWM8
        |=> wave_ff == ($past(cnt_ff[BYTE_W-1:0]) < $past(top_in[CNT_W-1:BYTE_W])))
        else $error("pwm output disagrees with duty byte");
    cov_periodic_wrap: cover property (@(posedge ref_clk_in) disable iff (rst_in)
        run_in && mode_in == MODE_PERIODIC && full_hit);
    cov_pwm_wave: cover property (@(posedge ref_clk_in) disable iff (rst_in)
        wave_ff ##1 !wave_ff);
endmodule
`default_nettype wire

/* File: tbcc_top.sv */
`default_nettype none
module tbcc_top
    import tbcc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [DATA_W-1:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [DATA_W-1:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // timer pins
    input wire logic capture_trig_in,
    output logic wave_out,
    output logic top_match_out
);
    logic wait_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;
    logic [IDX_W-1:0] idx;
    logic wr_go;
    logic [BYTE_W-1:0] wbyte;
    logic [BYTE_W-1:0] ctrl_ff;
    logic [CNT_W-1:0] capcmp_ff;
    logic capt_flag_ff;
    logic match_flag_ff;
    logic trig_s1_ff;
    logic trig_s2_ff;
    logic trig_s3_ff;
    logic trig_lvl_ff;
    logic trig_edge;
    logic capt_evt;
    logic run;
    logic [MODE_W-1:0] mode;
    logic [CNT_W-1:0] cnt;
    logic cnt_match;
    logic wr_cnt_lo;
    logic wr_cnt_hi;
    logic wr_capcmp_lo;
    logic wr_capcmp_hi;
    logic wr_status;

    assign idx = avs_address_in[ADDR_W-1:2];
    assign wbyte = avs_writedata_in[BYTE_W-1:0];
    // a write lands only at the edge where the master sees waitrequest low
    assign wr_go = avs_write_in && !wait_ff && avs_byteenable_in[0];
    assign wr_cnt_lo = wr_go && (idx == IDX_CNT_LO);
    assign wr_cnt_hi = wr_go && (idx == IDX_CNT_HI);
    assign wr_capcmp_lo = wr_go && (idx == IDX_CAPCMP_LO);
    assign wr_capcmp_hi = wr_go && (idx == IDX_CAPCMP_HI);
    assign wr_status = wr_go && (idx == IDX_STATUS);
    assign run = ctrl_ff[CTRL_EN_BIT];
    assign mode = ctrl_ff[CTRL_MODE_LSB +: MODE_W];
    assign avs_readdata_out = rdata_ff;
    assign avs_waitrequest_out = wait_ff;

    // one wait state per access: low for exactly one cycle, then high again
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= !((avs_read_in || avs_write_in) && wait_ff);
        end
    end

    always_comb begin
        nxt_rdata = RDATA_RST;
        case (idx)
            IDX_CTRL: nxt_rdata[BYTE_W-1:0] = ctrl_ff;
            IDX_STATUS: begin
                nxt_rdata[STAT_CAPT_BIT] = capt_flag_ff;
                nxt_rdata[STAT_MATCH_BIT] = match_flag_ff;
                nxt_rdata[STAT_RUN_BIT] = run;
                nxt_rdata[STAT_WAVE_BIT] = wave_out;
            end
            IDX_CNT_LO: nxt_rdata[BYTE_W-1:0] = cnt[BYTE_W-1:0];
            IDX_CNT_HI: nxt_rdata[BYTE_W-1:0] = cnt[CNT_W-1:BYTE_W];
            // low at base, high at base plus one
            IDX_CAPCMP_LO: nxt_rdata[BYTE_W-1:0] = capcmp_ff[BYTE_W-1:0];
            IDX_CAPCMP_HI: nxt_rdata[BYTE_W-1:0] = capcmp_ff[CNT_W-1:BYTE_W];
            default: nxt_rdata = RDATA_RST;
        endcase
    end

    // read data is captured while waitrequest is high and stands through the low cycle
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rdata_ff <= RDATA_RST;
        end else if (avs_read_in && wait_ff) begin
            rdata_ff <= nxt_rdata;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ctrl_ff <= CTRL_RST;
        end else if (wr_go && idx == IDX_CTRL) begin
            ctrl_ff <= wbyte;
        end
    end

    // trigger pin: three stages, a change counts once stages two and three agree
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            trig_s1_ff <= 1'b0;
            trig_s2_ff <= 1'b0;
            trig_s3_ff <= 1'b0;
            trig_lvl_ff <= 1'b0;
        end else begin
            trig_s1_ff <= capture_trig_in;
            trig_s2_ff <= trig_s1_ff;
            trig_s3_ff <= trig_s2_ff;
            if (trig_s2_ff == trig_s3_ff) begin
                trig_lvl_ff <= trig_s3_ff;
            end
        end
    end

    assign trig_edge = trig_s2_ff && trig_s3_ff && !trig_lvl_ff;
    assign capt_evt = run && (mode == MODE_CAPTURE) && trig_edge;

    // capture beats a software write in the same cycle
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            capcmp_ff <= CAPCMP_RST;
        end else if (capt_evt) begin
            capcmp_ff <= cnt;
        end else if (wr_capcmp_lo) begin
            capcmp_ff[BYTE_W-1:0] <= wbyte;
        end else if (wr_capcmp_hi) begin
            capcmp_ff[CNT_W-1:BYTE_W] <= wbyte;
        end
    end

    // sticky flags, cleared by writing one; a new event in the clear cycle wins
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            capt_flag_ff <= 1'b0;
            match_flag_ff <= 1'b0;
        end else begin
            if (capt_evt) begin
                capt_flag_ff <= 1'b1;
            end else if (wr_status && wbyte[STAT_CAPT_BIT]) begin
                capt_flag_ff <= 1'b0;
            end
            if (cnt_match) begin
                match_flag_ff <= 1'b1;
            end else if (wr_status && wbyte[STAT_MATCH_BIT]) begin
                match_flag_ff <= 1'b0;
            end
        end
    end

    tbcc_counter tbcc_counter_i (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .run_in(run),
        .mode_in(mode),
        .top_in(capcmp_ff),
        .wr_lo_in(wr_cnt_lo),
        .wr_hi_in(wr_cnt_hi),
        .wr_data_in(wbyte),
        .cnt_out(cnt),
        .match_out(cnt_match),
        .wave_out(wave_out)
    );

    assign top_match_out = cnt_match;

    chk_wait_one: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !wait_ff |=> wait_ff)
        else $error("waitrequest low for more than one cycle");
    chk_capcmp_hi_read: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        avs_read_in && wait_ff && idx == IDX_CAPCMP_HI && !capt_evt
        |=> rdata_ff == {24'h00_0000, $past(capcmp_ff[CNT_W-1:BYTE_W])})
        else $error("capture/compare high byte read at wrong index");
    chk_cnt_hi_read: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        avs_read_in && wait_ff && idx == IDX_CNT_HI
        |=> rdata_ff[BYTE_W-1:0] == $past(cnt[CNT_W-1:BYTE_W]))
        else $error("counter high byte read wrong");
    chk_capture_load: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        capt_evt |=> capcmp_ff == $past(cnt) && capt_flag_ff)
        else $error("capture did not load counter value");
    chk_capcmp_write: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        wr_capcmp_lo && !capt_evt |=> capcmp_ff[BYTE_W-1:0] == $past(wbyte))
        else $error("capture/compare low byte write lost");
    // a pin held for the shortest legal time of three cycles must still capture
    chk_trig_filter: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        $rose(capture_trig_in) && run && mode == MODE_CAPTURE ##1 capture_trig_in [*2]
        |-> ##[1:2] capt_flag_ff)
        else $error("stable trigger edge produced no capture");
    cov_capture: cover property (@(posedge ref_clk_in) disable iff (rst_in) capt_evt);
    cov_write_read: cover property (@(posedge ref_clk_in) disable iff (rst_in)
        wr_capcmp_hi ##[1:8] (avs_read_in && !wait_ff && idx == IDX_CAPCMP_HI));
endmodule
`default_nettype wire

/* File: tbcc_top_bench.sv */
`default_nettype none
module tbcc_top_bench
    import tbcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [ADDR_W-1:0] address = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [DATA_W-1:0] wdata = '0;
    logic [3:0] be = 4'h0;
    logic trig = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic waitreq;
    logic wave;
    logic top_match;
    logic [DATA_W-1:0] q;
    logic [DATA_W-1:0] c1;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    int n;
    int t0;
    int hi_cnt;
    int m_cnt;

    always #2.5 ref_clk_in = ~ref_clk_in;

    tbcc_top tbcc_top_i (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .avs_address_in(address),
        .avs_read_in(rd),
        .avs_write_in(wr),
        .avs_writedata_in(wdata),
        .avs_byteenable_in(be),
        .avs_readdata_out(rdata),
        .avs_waitrequest_out(waitreq),
        .capture_trig_in(trig),
        .wave_out(wave),
        .top_match_out(top_match)
    );

    // counted on the falling edge so rising-edge readers never race it
    always @(negedge ref_clk_in) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            $display("ERROR at %0t: run timed out", $time);
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // values read right after an edge are those the edge sampled; the design's flops
    // update later in the same step, so the request holds until waitrequest is seen low
    task automatic bus(input logic is_rd, input logic [IDX_W-1:0] idx,
            input logic [BYTE_W-1:0] d, input logic [3:0] b, output logic [DATA_W-1:0] r);
        @(posedge ref_clk_in);
        rd <= is_rd;
        wr <= ~is_rd;
        address <= {idx, 2'b00};
        wdata <= {24'h00_0000, d};
        be <= b;
        do begin
            @(posedge ref_clk_in);
        end while (waitreq !== 1'b0);
        r = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wr_reg(input logic [IDX_W-1:0] idx, input logic [BYTE_W-1:0] d);
        logic [DATA_W-1:0] r;
        bus(1'b0, idx, d, 4'h1, r);
    endtask

    task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [BYTE_W-1:0] e);
        logic [DATA_W-1:0] r;
        bus(1'b1, idx, 8'h00, 4'h0, r);
        check(r, {24'h00_0000, e});
    endtask

    // stop, clear the counter, load both compare bytes, then start in the given mode
    task automatic prep(input logic [MODE_W-1:0] mode, input logic [BYTE_W-1:0] lo,
            input logic [BYTE_W-1:0] hi);
        wr_reg(IDX_CTRL, 8'h00);
        wr_reg(IDX_CNT_LO, 8'h00);
        wr_reg(IDX_CNT_HI, 8'h00);
        wr_reg(IDX_CAPCMP_LO, lo);
        wr_reg(IDX_CAPCMP_HI, hi);
        wr_reg(IDX_CTRL, 8'h01 | ({6'h00, mode} << CTRL_MODE_LSB));
    endtask

    task automatic wait_match(output int k);
        k = 0;
        do begin
            @(negedge ref_clk_in);
            k++;
        end while (top_match !== 1'b1 && k < 300);
    endtask

    task automatic pulse_trig();
        @(posedge ref_clk_in);
        trig <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        trig <= 1'b0;
    endtask

    task automatic test_reset_and_bytes();
        rd_chk(IDX_CNT_LO, 8'h00);
        rd_chk(IDX_CNT_HI, 8'h00);
        rd_chk(IDX_CAPCMP_LO, 8'h00);
        rd_chk(IDX_CAPCMP_HI, 8'h00);
        rd_chk(6'h3F, 8'h00);
        wr_reg(IDX_CAPCMP_LO, 8'hA5);
        wr_reg(IDX_CAPCMP_LO + 6'h01, 8'h5A);
        bus(1'b0, IDX_CAPCMP_LO, 8'hFF, 4'h0, q);
        rd_chk(IDX_CAPCMP_LO, 8'hA5);
        rd_chk(IDX_CAPCMP_LO + 6'h01, 8'h5A);
        wr_reg(IDX_CNT_LO, 8'h34);
        wr_reg(IDX_CNT_HI, 8'h12);
        rd_chk(IDX_CNT_LO, 8'h34);
        rd_chk(IDX_CNT_HI, 8'h12);
    endtask

    task automatic test_top_modes();
        prep(MODE_PERIODIC, 8'h05, 8'h00);
        wait_match(n);
        wait_match(n);
        check(n, 6);
        prep(MODE_SINGLE, 8'h03, 8'h00);
        repeat (20) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        check(top_match, 1'b1);
        rd_chk(IDX_CNT_LO, 8'h03);
        rd_chk(IDX_CNT_HI, 8'h00);
    endtask

    // absolute capture latency is not assumed: two captures 40 edges apart differ by 40
    task automatic test_capture();
        prep(MODE_CAPTURE, 8'h00, 8'h00);
        // flags are sticky from the earlier modes: clear both, only the run bit stays
        wr_reg(IDX_STATUS, 8'h03);
        rd_chk(IDX_STATUS, 8'h04);
        @(posedge ref_clk_in);
        trig <= 1'b1;
        t0 = cycles;
        repeat (3) @(posedge ref_clk_in);
        trig <= 1'b0;
        repeat (6) @(posedge ref_clk_in);
        bus(1'b1, IDX_CAPCMP_LO, 8'h00, 4'h0, c1);
        while (cycles != t0 + 40) @(posedge ref_clk_in);
        trig <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        trig <= 1'b0;
        repeat (6) @(posedge ref_clk_in);
        bus(1'b1, IDX_CAPCMP_LO, 8'h00, 4'h0, q);
        check({24'h00_0000, q[7:0] - c1[7:0]}, 32'h0000_0028);
        rd_chk(IDX_STATUS, 8'h05);
        wr_reg(IDX_STATUS, 8'h01);
        rd_chk(IDX_STATUS, 8'h04);
    endtask

    task automatic test_pwm();
        prep(MODE_PWM8, 8'h09, 8'h03);
        repeat (5) @(posedge ref_clk_in);
        hi_cnt = 0;
        m_cnt = 0;
        repeat (50) begin
            @(negedge ref_clk_in);
            if (wave === 1'b1) hi_cnt++;
            if (top_match === 1'b1) m_cnt++;
        end
        check(hi_cnt, 15);
        check(m_cnt, 5);
        pulse_trig();
        repeat (8) @(posedge ref_clk_in);
        rd_chk(IDX_CAPCMP_LO, 8'h09);
        rd_chk(IDX_CAPCMP_HI, 8'h03);
        rd_chk(IDX_CNT_HI, 8'h00);
    endtask

    initial begin
        repeat (5) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        test_reset_and_bytes();
        test_top_modes();
        test_capture();
        test_pwm();
        report_and_stop();
    end
endmodule
`default_nettype wire
